/* File: bcc_channel.sv */
`timescale 1ns/100ps
module bcc_channel (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // system bus master
  output logic             o_bus_req,
  input  wire logic        i_bus_grant,
  output logic      [23:0] o_bus_addr,
  output logic      [2:0]  o_space_code_pins,
  output logic             o_bus_rd,
  output logic             o_bus_wr,
  output logic             o_bus_upper,
  output logic             o_bus_lower,
  output logic      [15:0] o_bus_wdata,
  input  wire logic [15:0] i_bus_rdata,
  input  wire logic        i_bus_cycle_ack,
  input  wire logic        i_bus_err,
  // peripheral handshake
  input  wire logic        i_transfer_request_in,
  output logic             o_transfer_ack_out,
  input  wire logic        i_end_of_block,
  output logic             o_end_of_block,
  output logic             o_end_of_block_oe,
  // interrupt request
  output logic             o_irq_req
);
  import bcc_pkg::*;

  // ==========================================================
  // state
  logic [15:0] mode_q;
  logic [7:0]  flags_q, flags_set, flags_clr;
  logic [7:0]  fc_q;
  logic [23:0] src_q, dst_q;
  logic [15:0] cnt_q, cnt_nxt;
  logic [15:0] hold_q;
  bcc_state_e  state_q, state_d;
  logic        act_q, idx_q, eob_seen_q, pend_q, req_prev_q;
  logic [2:0]  off_q;
  logic [9:0]  win_q, used_q, bw_lim;
  logic [31:0] rdata_q;
  logic        bus_req_q, bus_rd_q, bus_wr_q, upper_q, lower_q;
  logic [23:0] bus_addr_q;
  logic [2:0]  fcp_q;
  logic [15:0] wdata_q;
  logic        ack_out_q, eob_q, eob_oe_q, irq_q;

  // ==========================================================
  // decode of mode bits
  logic       soft_rst, str, ext_mode, peripheral_side_select;
  logic       src_word, dst_word, nb_two, rd_word, wr_word;
  logic       is_rd, cyc_word, phase_end, periph_phase, go;
  logic [2:0] cyc_step;
  logic [23:0] cyc_addr;
  logic       ack_ok, err_hit, last_cyc, eob_in, wr_end;
  logic       mode_wr, flags_wr;
  logic       stop_hw;

  assign soft_rst = i_sys_rst | mode_q[BCC_M_RST];
  assign str      = mode_q[BCC_M_STR];
  assign ext_mode = mode_q[BCC_M_REQUEST_SOURCE_SELECT+1];
  assign peripheral_side_select      = mode_q[BCC_M_ECO];
  assign src_word = mode_q[BCC_M_SRC_OPERAND_WIDTH+:2] == BCC_SIZE_WORD;
  assign dst_word = mode_q[BCC_M_DST_OPERAND_WIDTH+:2] == BCC_SIZE_WORD;
  // a packed operand is two bytes unless only one byte remains
  assign nb_two   = (src_word | dst_word) & (cnt_q != 16'h0001);
  assign rd_word  = nb_two & src_word & ~src_q[0];
  assign wr_word  = nb_two & dst_word & ~dst_q[0];
  assign is_rd    = state_q == BCC_RD;
  assign cyc_word = is_rd ? rd_word : wr_word;
  // byte side facing a word side steps by two per cycle, like MOVEP
  always_comb begin
    if (cyc_word) begin
      cyc_step = 3'h2;
    end else if (is_rd ? (~src_word & dst_word) : (~dst_word & src_word)) begin
      cyc_step = 3'h2;
    end else begin
      cyc_step = 3'h1;
    end
  end
  assign cyc_addr  = (is_rd ? src_q : dst_q) + {21'h0, off_q};
  assign phase_end = cyc_word | idx_q | ~nb_two;
  assign periph_phase = ext_mode & (is_rd ? ~peripheral_side_select : peripheral_side_select);
  assign ack_ok    = act_q & i_bus_cycle_ack & ~i_bus_err;
  assign err_hit   = act_q & i_bus_err;
  assign cnt_nxt   = cnt_q - (nb_two ? 16'h0002 : 16'h0001);
  assign last_cyc  = (state_q == BCC_WR) & phase_end & (cnt_nxt == 16'h0000);
  assign wr_end    = (state_q == BCC_WR) & ack_ok & phase_end;
  // input is only looked at while this end is not driving the pin
  assign eob_in    = i_end_of_block & ~eob_oe_q & ack_ok
                   & (~ext_mode | periph_phase);
  assign mode_wr   = i_reg_wr & (i_reg_addr == BCC_OFF_MODE);
  assign flags_wr  = i_reg_wr & (i_reg_addr == BCC_OFF_FLAGS);

  // ==========================================================
  // request source
  always_comb begin
    case (mode_q[BCC_M_BT+:2])
      2'h0:    bw_lim = BCC_BW_75;
      2'h1:    bw_lim = BCC_BW_50;
      2'h2:    bw_lim = BCC_BW_25;
      default: bw_lim = BCC_BW_12;
    endcase
  end
  always_comb begin
    case (mode_q[BCC_M_REQUEST_SOURCE_SELECT+:2])
      BCC_REQ_LIMITED: go = str & (used_q < bw_lim);
      BCC_REQ_MAXRATE: go = str;
      BCC_REQ_EXT_LVL: go = str & i_transfer_request_in;
      BCC_REQ_EXT_EDG: go = str & pend_q;
      default:         go = 1'b0;
    endcase
  end

  // edge request is only latched once start is set
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      pend_q     <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= i_transfer_request_in;
      if (i_transfer_request_in & ~req_prev_q & str) begin
        pend_q <= 1'b1;
      end else if (state_q == BCC_ARB && i_bus_grant) begin
        pend_q <= 1'b0;
      end
    end
  end

  // window restarts whenever the channel is re-enabled
  always_ff @(posedge i_core_clk) begin
    if (soft_rst || !str) begin
      win_q  <= 10'h000;
      used_q <= 10'h000;
    end else begin
      win_q  <= win_q + 10'h001;
      if (win_q == 10'h3ff) begin
        used_q <= 10'h000;
      end else if (bus_req_q) begin
        used_q <= used_q + 10'h001;
      end
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      BCC_IDLE: if (go) state_d = BCC_ARB;
      BCC_ARB: begin
        if (!go) begin
          state_d = BCC_IDLE;
        end else if (i_bus_grant) begin
          state_d = BCC_RD;
        end
      end
      BCC_RD: begin
        if (err_hit) begin
          state_d = BCC_IDLE;
        end else if (ack_ok && phase_end) begin
          state_d = BCC_WR;
        end
      end
      BCC_WR: begin
        if (err_hit) begin
          state_d = BCC_IDLE;
        end else if (wr_end) begin
          // stopping takes effect only at an operand boundary
          state_d = (str && !stop_hw) ? BCC_ARB : BCC_IDLE;
        end
      end
      default: state_d = BCC_IDLE;
    endcase
  end
  assign stop_hw = cnt_nxt == 16'h0000 || eob_seen_q || eob_in;

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      state_q    <= BCC_IDLE;
      act_q      <= 1'b0;
      idx_q      <= 1'b0;
      off_q      <= 3'h0;
      eob_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if ((is_rd || state_q == BCC_WR) && !act_q) begin
        act_q <= 1'b1;
      end else if (ack_ok || err_hit) begin
        act_q <= 1'b0;
      end
      if (err_hit || state_q == BCC_IDLE) begin
        idx_q <= 1'b0;
        off_q <= 3'h0;
      end else if (ack_ok) begin
        idx_q <= ~phase_end;
        off_q <= phase_end ? 3'h0 : off_q + cyc_step;
      end
      if (eob_in) begin
        eob_seen_q <= 1'b1;
      end else if (err_hit || wr_end) begin
        eob_seen_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bus outputs, launched in the first cycle of each access
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      bus_req_q  <= 1'b0;
      bus_rd_q   <= 1'b0;
      bus_wr_q   <= 1'b0;
      upper_q    <= 1'b0;
      lower_q    <= 1'b0;
      bus_addr_q <= BCC_PTR_RST;
      fcp_q      <= 3'h0;
      wdata_q    <= 16'h0000;
      ack_out_q  <= 1'b0;
      eob_q      <= 1'b0;
      eob_oe_q   <= 1'b0;
    end else begin
      bus_req_q <= state_d != BCC_IDLE;
      if ((is_rd || state_q == BCC_WR) && !act_q) begin
        bus_rd_q   <= is_rd;
        bus_wr_q   <= ~is_rd;
        bus_addr_q <= cyc_addr;
        fcp_q      <= is_rd ? fc_q[2:0] : fc_q[6:4];
        upper_q    <= cyc_word | ~cyc_addr[0];
        lower_q    <= cyc_word | cyc_addr[0];
        if (cyc_word) begin
          wdata_q <= hold_q;
        end else begin
          wdata_q <= idx_q ? {2{hold_q[7:0]}} : {2{hold_q[15:8]}};
        end
        ack_out_q <= periph_phase;
        eob_q     <= last_cyc;
        eob_oe_q  <= last_cyc;
      end else if (ack_ok || err_hit) begin
        bus_rd_q  <= 1'b0;
        bus_wr_q  <= 1'b0;
        upper_q   <= 1'b0;
        lower_q   <= 1'b0;
        ack_out_q <= 1'b0;
        eob_q     <= 1'b0;
        eob_oe_q  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // holding latch, pointers, count (kept across stop)
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      hold_q <= 16'h0000;
    end else if (is_rd && ack_ok) begin
      if (cyc_word) begin
        hold_q <= i_bus_rdata;
      end else if (idx_q || !nb_two) begin
        hold_q[7:0] <= cyc_addr[0] ? i_bus_rdata[7:0] : i_bus_rdata[15:8];
        if (!nb_two) begin
          hold_q[15:8] <= cyc_addr[0] ? i_bus_rdata[7:0] : i_bus_rdata[15:8];
        end
      end else begin
        hold_q[15:8] <= cyc_addr[0] ? i_bus_rdata[7:0] : i_bus_rdata[15:8];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      src_q <= BCC_PTR_RST;
      dst_q <= BCC_PTR_RST;
      cnt_q <= BCC_CNT_RST;
      fc_q  <= BCC_FC_RST;
    end else begin
      if (i_reg_wr && i_reg_addr == BCC_OFF_SRC) begin
        src_q <= i_reg_wdata[23:0];
      end else if (is_rd && ack_ok && phase_end && mode_q[BCC_M_SRC_STEP_ENABLE]) begin
        src_q <= src_q + {21'h0, off_q + cyc_step};
      end
      if (i_reg_wr && i_reg_addr == BCC_OFF_DST) begin
        dst_q <= i_reg_wdata[23:0];
      end else if (wr_end && mode_q[BCC_M_DST_STEP_ENABLE]) begin
        dst_q <= dst_q + {21'h0, off_q + cyc_step};
      end
      if (i_reg_wr && i_reg_addr == BCC_OFF_CNT) begin
        cnt_q <= i_reg_wdata[15:0];
      end else if (wr_end) begin
        cnt_q <= cnt_nxt;
      end
      if (i_reg_wr && i_reg_addr == BCC_OFF_FC) begin
        fc_q <= i_reg_wdata[7:0];
      end
    end
  end

  // ==========================================================
  // mode word and event flags
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      mode_q <= BCC_MODE_RST;
    end else if (mode_wr) begin
      mode_q <= {1'b0, i_reg_wdata[14:0]};
    end else if (err_hit || (wr_end && stop_hw)) begin
      mode_q[BCC_M_STR] <= 1'b0;
    end
  end

  always_comb begin
    flags_set = 8'h00;
    flags_set[BCC_F_BES]  = err_hit & is_rd;
    flags_set[BCC_F_BED]  = err_hit & ~is_rd;
    flags_set[BCC_F_DONE] = wr_end & stop_hw;
    // only a peripheral-driven end counts, not an exhausted count
    flags_set[BCC_F_DNS]  = eob_in & periph_phase & nb_two
                          & ~cyc_word & ~idx_q;
    flags_clr = flags_wr ? i_reg_wdata[7:0] : 8'h00;
  end

  // an event in the same cycle as its clear still lands
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      flags_q <= BCC_FLAGS_RST;
    end else begin
      flags_q <= ((flags_q & ~flags_clr) | flags_set) & 8'h0f;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flags_q[BCC_F_DONE] & mode_q[BCC_M_NORMAL_IRQ_ENABLE])
             | ((flags_q[BCC_F_BES] | flags_q[BCC_F_BED])
                & mode_q[BCC_M_ERROR_IRQ_ENABLE]);
    end
  end

  // ==========================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        BCC_OFF_MODE:  rdata_q <= {16'h0000, mode_q};
        BCC_OFF_SRC:   rdata_q <= {8'h00, src_q};
        BCC_OFF_DST:   rdata_q <= {8'h00, dst_q};
        BCC_OFF_FC:    rdata_q <= {24'h0, 1'b1, fc_q[6:4], 1'b1, fc_q[2:0]};
        BCC_OFF_CNT:   rdata_q <= {16'h0000, cnt_q};
        BCC_OFF_FLAGS: rdata_q <= {24'h0, flags_q};
        default:       rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign o_reg_rdata        = rdata_q;
  assign o_bus_req          = bus_req_q;
  assign o_bus_addr         = bus_addr_q;
  assign o_space_code_pins  = fcp_q;
  assign o_bus_rd           = bus_rd_q;
  assign o_bus_wr           = bus_wr_q;
  assign o_bus_upper        = upper_q;
  assign o_bus_lower        = lower_q;
  assign o_bus_wdata        = wdata_q;
  assign o_transfer_ack_out = ack_out_q;
  assign o_end_of_block     = eob_q;
  assign o_end_of_block_oe  = eob_oe_q;
  assign o_irq_req          = irq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_soft_reset_clear: assert property (
    mode_q[BCC_M_RST] |=> mode_q == 16'h0000 && flags_q == 8'h00
                          && state_q == BCC_IDLE && !o_bus_rd)
    else $error("soft reset left channel state behind");
  a_start_req_delay: assert property (
    (state_q == BCC_IDLE && !str && !mode_q[BCC_M_RST] && mode_wr
     && i_reg_wdata[BCC_M_STR] && !i_reg_wdata[BCC_M_RST]
     && i_reg_wdata[BCC_M_REQUEST_SOURCE_SELECT+:2] == BCC_REQ_MAXRATE)
    |=> !o_bus_req ##1 o_bus_req)
    else $error("bus request not one clock after start");
  a_ext_wait_start: assert property (
    (state_q == BCC_IDLE && !str) |=> state_q != BCC_ARB)
    else $error("channel left idle without start");
  a_stop_boundary: assert property (
    (wr_end && !str && !stop_hw && !mode_wr) |=> state_q == BCC_IDLE
                                              && cnt_q == $past(cnt_nxt))
    else $error("stop did not hold count at operand boundary");
  a_done_clears_start: assert property (
    (wr_end && stop_hw && !mode_wr) |=> !str && flags_q[BCC_F_DONE])
    else $error("completion did not clear start");
  a_space_code_pins: assert property (
    $rose(o_bus_wr) |-> o_space_code_pins == $past(fc_q[6:4]))
    else $error("write cycle space code wrong");
  a_read_err_flag: assert property (
    (err_hit && is_rd) |=> flags_q[BCC_F_BES] && state_q == BCC_IDLE
                           && !o_bus_rd)
    else $error("read bus error not handled");
  a_write_err_flag: assert property (
    (err_hit && !is_rd) |=> flags_q[BCC_F_BED] && state_q == BCC_IDLE
                            && !o_bus_wr)
    else $error("write bus error not handled");
  a_flags_w1c: assert property (
    (flags_wr && flags_set == 8'h00)
    |=> flags_q == ($past(flags_q) & ~$past(i_reg_wdata[7:0])))
    else $error("event flag clear wrong");
  a_ack_external: assert property (
    o_transfer_ack_out |-> ext_mode && (o_bus_rd || o_bus_wr))
    else $error("ack out outside external access");
  a_irq_gating: assert property (
    (!mode_q[BCC_M_NORMAL_IRQ_ENABLE] && !mode_q[BCC_M_ERROR_IRQ_ENABLE]) [*2] |-> !o_irq_req)
    else $error("interrupt raised while disabled");

  c_done: cover property (wr_end && stop_hw);
  c_read_err: cover property (err_hit && is_rd);
  c_unsynced: cover property (flags_set[BCC_F_DNS]);
  c_stop_resume: cover property (wr_end && !str ##[1:50] state_q == BCC_ARB);
endmodule

/* File: bcc_channel_tb.sv */
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the copy channel
module bcc_channel_tb;
  import bcc_pkg::*;
  logic        clk, rst, reg_wr, reg_rd, bus_req, grant, bus_rd, bus_wr;
  logic        upper, lower, ack, err, transfer_request_in, transfer_ack_out, eob_in, eob_out, eob_oe;
  logic        peri_eob, irq, err_en, eob_seen, ack_seen;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val, cnt_a;
  logic [23:0] bus_addr, err_addr;
  logic [2:0]  fc_pins;
  logic [15:0] wdata, rdata;
  logic [5:0]  wait_cyc;
  int          num_errors, samples_checked, cycles;
  assign eob_in = eob_oe ? eob_out : peri_eob;
  bcc_channel i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .o_bus_req(bus_req), .i_bus_grant(grant),
    .o_bus_addr(bus_addr), .o_space_code_pins(fc_pins), .o_bus_rd(bus_rd),
    .o_bus_wr(bus_wr), .o_bus_upper(upper), .o_bus_lower(lower),
    .o_bus_wdata(wdata), .i_bus_rdata(rdata), .i_bus_cycle_ack(ack),
    .i_bus_err(err), .i_transfer_request_in(transfer_request_in), .o_transfer_ack_out(transfer_ack_out),
    .i_end_of_block(eob_in), .o_end_of_block(eob_out),
    .o_end_of_block_oe(eob_oe), .o_irq_req(irq));
  bcc_mem_model i_mem (.i_core_clk(clk), .i_sys_rst(rst), .i_bus_req(bus_req),
    .o_bus_grant(grant), .i_bus_addr(bus_addr), .i_bus_rd(bus_rd),
    .i_bus_wr(bus_wr), .i_bus_upper(upper), .i_bus_lower(lower),
    .i_bus_wdata(wdata), .o_bus_rdata(rdata), .o_bus_cycle_ack(ack),
    .o_bus_err(err), .i_wait(wait_cyc), .i_err_en(err_en),
    .i_err_addr(err_addr));
  // ==========================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string n);
    logic [31:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask
  task automatic go(input logic [31:0] s, d, n, m);
    wr(BCC_OFF_SRC, s);
    wr(BCC_OFF_DST, d);
    wr(BCC_OFF_CNT, n);
    wr(BCC_OFF_MODE, m);
  endtask
  // polling is bounded so a silent channel ends in a mismatch, not a hang
  task automatic wait_end();
    rd_val = 32'h0;
    for (int i = 0; i < 3000 && rd_val == 32'h0; i++) begin
      rd(BCC_OFF_FLAGS, rd_val);
    end
  endtask
  // ==========================================================
  // clock, watchdog and pin monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  always @(posedge clk) begin
    if (!rst && bus_rd) chk("src code", 32'h1, {29'h0, fc_pins});
    if (!rst && bus_wr) chk("dst code", 32'h5, {29'h0, fc_pins});
    if (!rst && transfer_ack_out) chk("ack side", 32'h1, {31'h0, bus_rd});
    if (eob_oe) eob_seen = 1'b1;
    if (transfer_ack_out) ack_seen = 1'b1;
  end
  // ==========================================================
  // scenarios
  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0; transfer_request_in = 1'b0; peri_eob = 1'b0; err_en = 1'b0;
    err_addr = 24'h0; wait_cyc = 6'h01; eob_seen = 1'b0; ack_seen = 1'b0;
    num_errors = 0; samples_checked = 0; cycles = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(BCC_OFF_MODE, 32'h0, "mode reset");
    rd_chk(BCC_OFF_FLAGS, 32'h0, "flags reset");
    rd_chk(8'h18, 32'h0, "unmapped");
    wr(BCC_OFF_FC, 32'h51);
    rd_chk(BCC_OFF_FC, 32'hd9, "func code");
    go(32'h10, 32'h40, 32'h4, 32'h27a1);
    wait_end();
    chk("done flags", 32'h1, rd_val);
    chk("normal irq", 32'h1, {31'h0, irq});
    chk("copy w1", 32'h09f6, {16'h0, i_mem.mem[33]});
    rd_chk(BCC_OFF_MODE, 32'h27a0, "start cleared");
    rd_chk(BCC_OFF_SRC, 32'h14, "src after");
    rd_chk(BCC_OFF_DST, 32'h44, "dst after");
    rd_chk(BCC_OFF_CNT, 32'h0, "count after");
    // soft reset in mid-cycle against a slow memory
    wait_cyc <= 6'd30;
    go(32'h10, 32'h40, 32'h20, 32'h07a1);
    repeat (20) @(posedge clk);
    wr(BCC_OFF_MODE, 32'h2);
    @(posedge clk);
    chk("bus idle", 32'h0, {30'h0, bus_rd, bus_wr});
    rd_chk(BCC_OFF_MODE, 32'h0, "mode soft");
    rd_chk(BCC_OFF_FLAGS, 32'h0, "flags soft");
    // stop mid-block, then resume from kept pointers
    wait_cyc <= 6'd3;
    go(32'h100, 32'h180, 32'h10, 32'h07a1);
    repeat (25) @(posedge clk);
    wr(BCC_OFF_MODE, 32'h07a0);
    repeat (30) @(posedge clk);
    rd(BCC_OFF_CNT, cnt_a);
    repeat (20) @(posedge clk);
    rd_chk(BCC_OFF_CNT, cnt_a, "count held");
    chk("mid count", 32'h1, {31'h0, cnt_a != 32'h0 && cnt_a != 32'h10});
    wr(BCC_OFF_MODE, 32'h07a1);
    wait_end();
    chk("resume w7", 32'h8778, {16'h0, i_mem.mem[199]});
    rd_chk(BCC_OFF_SRC, 32'h110, "src resumed");
    wr(BCC_OFF_FLAGS, 32'h0);
    rd_chk(BCC_OFF_FLAGS, 32'h1, "w1c zero");
    wr(BCC_OFF_FLAGS, 32'h0f);
    rd_chk(BCC_OFF_FLAGS, 32'h0, "w1c one");
    // source wraps at 24 bits, destination held
    wait_cyc <= 6'd1;
    go(32'habfffffe, 32'h80, 32'h4, 32'h06a1);
    wait_end();
    rd_chk(BCC_OFF_SRC, 32'h2, "src wrap");
    rd_chk(BCC_OFF_DST, 32'h80, "dst fixed");
    chk("wrap data", 32'h00ff, {16'h0, i_mem.mem[64]});
    wr(BCC_OFF_FLAGS, 32'h0f);
    // bus errors on read then write, error irq off then on
    for (int k = 0; k < 2; k++) begin
      err_en <= 1'b1;
      err_addr <= (k == 1) ? 24'h40 : 24'h10;
      go(32'h10, 32'h40, 32'h4, 32'h07a1 | (32'(k) << 12));
      wait_end();
      chk("err flags", (k == 1) ? 32'h2 : 32'h4, rd_val);
      chk("err irq", 32'(k), {31'h0, irq});
      err_en <= 1'b0;
      wr(BCC_OFF_FLAGS, 32'h0f);
    end
    // external level request ignored until start
    transfer_request_in <= 1'b1;
    go(32'h10, 32'ha0, 32'h2, 32'h0ba0);
    repeat (30) @(posedge clk);
    chk("no req", 32'h0, {31'h0, bus_req});
    wr(BCC_OFF_MODE, 32'h0ba1);
    wait_end();
    chk("ext done", 32'h1, rd_val);
    chk("eob out", 32'h1, {31'h0, eob_seen});
    chk("ack out", 32'h1, {31'h0, ack_seen});
    chk("ext data", 32'h08f7, {16'h0, i_mem.mem[80]});
    wr(BCC_OFF_FLAGS, 32'h0f);
    // end-of-block input ends at the operand boundary; on a packed pair
    // the second peripheral byte still moves and the unsynced flag rises
    peri_eob <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      go(32'h20, 32'hc0, 32'h8, (k == 1) ? 32'h0b61 : 32'h07a1);
      wait_end();
      repeat (20) @(posedge clk);
      rd_chk(BCC_OFF_FLAGS, (k == 1) ? 32'h9 : 32'h1, "eob flags");
      rd_chk(BCC_OFF_CNT, 32'h6, "eob count");
      wr(BCC_OFF_FLAGS, 32'h0f);
    end
    chk("pack data", 32'h1011, {16'h0, i_mem.mem[96]});
    peri_eob <= 1'b0;
    // edge request: an edge before start is dropped, one after it served
    transfer_request_in <= 1'b0;
    go(32'h10, 32'he0, 32'h2, 32'h0fa0);
    transfer_request_in <= 1'b1;
    repeat (2) @(posedge clk);
    wr(BCC_OFF_MODE, 32'h0fa1);
    repeat (30) @(posedge clk);
    chk("no edge req", 32'h0, {31'h0, bus_req});
    transfer_request_in <= 1'b0;
    repeat (2) @(posedge clk);
    transfer_request_in <= 1'b1;
    wait_end();
    chk("edge done", 32'h1, rd_val);
    chk("edge data", 32'h08f7, {16'h0, i_mem.mem[112]});
    transfer_request_in <= 1'b0;
    wr(BCC_OFF_FLAGS, 32'h0f);
    // smallest share parks a long block until the next window
    go(32'h10, 32'h1c0, 32'h40, 32'h03ad);
    repeat (400) @(posedge clk);
    rd(BCC_OFF_CNT, cnt_a);
    chk("rate idle", 32'h0, {31'h0, bus_req});
    chk("rate part", 32'h1, {31'h0, cnt_a != 32'h0});
    wait_end();
    chk("rate done", 32'h1, rd_val);
    wr(BCC_OFF_FLAGS, 32'h0f);
    // odd count ends in mid-word without the unsynced flag
    go(32'h20, 32'h60, 32'h3, 32'h07a1);
    wait_end();
    chk("odd flags", 32'h1, rd_val);
    chk("odd byte", 32'h11ce, {16'h0, i_mem.mem[49]});
    complete_run();
  end
endmodule

/* File: bcc_mem_model.sv */
`timescale 1ns/100ps
// ==========================================================
// system bus memory that answers the copy channel
module bcc_mem_model (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // bus slave side
  input  wire logic        i_bus_req,
  output logic             o_bus_grant,
  input  wire logic [23:0] i_bus_addr,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic        i_bus_upper,
  input  wire logic        i_bus_lower,
  input  wire logic [15:0] i_bus_wdata,
  output logic      [15:0] o_bus_rdata,
  output logic             o_bus_cycle_ack,
  output logic             o_bus_err,
  // scenario knobs
  input  wire logic [5:0]  i_wait,
  input  wire logic        i_err_en,
  input  wire logic [23:0] i_err_addr
);
  logic [15:0] mem [0:255];
  logic [15:0] rdata_q;
  logic [5:0]  cnt_q;
  logic        served_q;
  logic        hit;
  assign hit = i_err_en && (i_bus_addr == i_err_addr);
  // between acks the lines show the inverse, so stale data never matches
  assign o_bus_rdata = o_bus_cycle_ack ? rdata_q : ~rdata_q;
  // grant follows request one clock later; no other master competes
  always @(posedge i_core_clk) begin
    o_bus_grant <= i_bus_req && !i_sys_rst;
  end
  always @(posedge i_core_clk) begin
    o_bus_cycle_ack <= 1'b0;
    o_bus_err <= 1'b0;
    // contents are reloaded only by the hardware reset
    if (i_sys_rst) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= {i[7:0], ~i[7:0]};
      end
    end
    if (i_sys_rst || !(i_bus_rd || i_bus_wr)) begin
      cnt_q <= 6'h00;
      served_q <= 1'b0;
    end else if (!served_q && cnt_q != i_wait) begin
      cnt_q <= cnt_q + 6'h01;
    end else if (!served_q) begin
      served_q <= 1'b1;
      o_bus_err <= hit;
      o_bus_cycle_ack <= !hit;
      rdata_q <= mem[i_bus_addr[8:1]];
      if (i_bus_wr && !hit && i_bus_upper) begin
        mem[i_bus_addr[8:1]][15:8] <= i_bus_wdata[15:8];
      end
      if (i_bus_wr && !hit && i_bus_lower) begin
        mem[i_bus_addr[8:1]][7:0] <= i_bus_wdata[7:0];
      end
    end
  end
endmodule

/* File: bcc_pkg.sv */
package bcc_pkg;
  // ==========================================================
  // register map (byte offsets on the register port)
  localparam logic [7:0]  BCC_OFF_MODE  = 8'h00;
  localparam logic [7:0]  BCC_OFF_SRC   = 8'h04;
  localparam logic [7:0]  BCC_OFF_DST   = 8'h08;
  localparam logic [7:0]  BCC_OFF_FC    = 8'h0c;
  localparam logic [7:0]  BCC_OFF_CNT   = 8'h10;
  localparam logic [7:0]  BCC_OFF_FLAGS = 8'h14;
  // ==========================================================
  // channel_mode_word fields
  localparam int BCC_M_STR   = 0;
  localparam int BCC_M_RST   = 1;
  localparam int BCC_M_BT    = 2;
  localparam int BCC_M_DST_OPERAND_WIDTH = 4;
  localparam int BCC_M_SRC_OPERAND_WIDTH = 6;
  localparam int BCC_M_DST_STEP_ENABLE  = 8;
  localparam int BCC_M_SRC_STEP_ENABLE  = 9;
  localparam int BCC_M_REQUEST_SOURCE_SELECT  = 10;
  localparam int BCC_M_ERROR_IRQ_ENABLE  = 12;
  localparam int BCC_M_NORMAL_IRQ_ENABLE  = 13;
  localparam int BCC_M_ECO   = 14;
  // channel_event_flags fields
  localparam int BCC_F_DONE = 0;
  localparam int BCC_F_BED  = 1;
  localparam int BCC_F_BES  = 2;
  localparam int BCC_F_DNS  = 3;
  // ==========================================================
  // reset values
  localparam logic [15:0] BCC_MODE_RST  = 16'h0000;
  localparam logic [7:0]  BCC_FLAGS_RST = 8'h00;
  localparam logic [7:0]  BCC_FC_RST    = 8'h00;
  localparam logic [23:0] BCC_PTR_RST   = 24'h000000;
  localparam logic [15:0] BCC_CNT_RST   = 16'h0000;
  // ==========================================================
  // encodings
  localparam logic [1:0] BCC_REQ_LIMITED = 2'h0;
  localparam logic [1:0] BCC_REQ_MAXRATE = 2'h1;
  localparam logic [1:0] BCC_REQ_EXT_LVL = 2'h2;
  localparam logic [1:0] BCC_REQ_EXT_EDG = 2'h3;
  localparam logic [1:0] BCC_SIZE_WORD   = 2'h2;
  // ==========================================================
  // bandwidth window (1024 clocks) and per-BT allowances
  localparam logic [9:0] BCC_BW_75  = 10'h300;
  localparam logic [9:0] BCC_BW_50  = 10'h200;
  localparam logic [9:0] BCC_BW_25  = 10'h100;
  localparam logic [9:0] BCC_BW_12  = 10'h080;
  typedef enum logic [1:0] {
    BCC_IDLE = 2'b00,
    BCC_ARB  = 2'b01,
    BCC_RD   = 2'b10,
    BCC_WR   = 2'b11
  } bcc_state_e;
endpackage
